// [core/spt_pkg.sv]
`default_nettype none
package spt_pkg;
  // bus base address after reset, 1011000b
  localparam logic [6:0] DEV_ADDR_RESET = 7'h58;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int CFG_DBL_BIT = 0;
  localparam int CFG_SPI_BIT = 1;
  localparam int ADDR_BIT_TWO = 2;
  // register map, byte addresses in the 64KB space
  localparam logic [15:0] USER_RAM_BASE = 16'h8000;
  localparam int USER_RAM_BYTES = 16;
  localparam logic [15:0] BASE_ADDR_OFFSET = 16'hfff0;
  localparam logic [15:0] PORT_CFG_OFFSET = 16'hfff1;
  localparam logic [15:0] PORT_STATUS_OFFSET = 16'hfff2;
  localparam logic [15:0] PAGE_OFFSET_DBL = 16'hfffc;
  localparam logic [7:0] PAGE_OFFSET_SGL = 8'hfc;
  localparam logic [7:0] PAGE_HIGH_BYTE = 8'hff;
  localparam logic [31:0] PAGE_RESET = 32'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // supported bus rates; link sampling clock must be far above the top rate
  localparam int BUS_RATE_STD_HZ = 100_000;
  localparam int BUS_RATE_FAST_HZ = 400_000;
  localparam int BUS_RATE_PLUS_HZ = 1_000_000;
  localparam int CORE_CLK_HZ = 125_000_000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_IGNORE, ST_RX, ST_ACK, ST_WAIT, ST_TX, ST_TXACK
  } spt_state_t;

  typedef enum logic [1:0] {
    ROLE_DEV, ROLE_OFF_HI, ROLE_OFF_LO, ROLE_DATA
  } spt_role_t;
endpackage : spt_pkg
`default_nettype wire

// [core/spt_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module spt_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule : spt_sync
`default_nettype wire

// [core/spt_reg_store.sv]
`timescale 1ns/100ps
`default_nettype none
module spt_reg_store
  import spt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // one access per strobe
  input wire logic acc_stb,
  input wire logic acc_wr,
  input wire logic [15:0] acc_ptr,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] rdata_q,
  // burst end and stored configuration
  input wire logic commit,
  input wire logic cfg_load_stb,
  input wire logic [6:0] cfg_load_base,
  input wire logic bit_two_strap_en,
  input wire logic bit_two_strap_s,
  input wire logic strap_spi_s,
  input wire logic seq_done,
  // active configuration
  output logic [6:0] base_act_q,
  output logic [1:0] cfg_act_q,
  output logic cfg_upd_q
);
  logic [31:0] page_q;
  logic [6:0] base_sh_q;
  logic [1:0] cfg_sh_q;
  logic [7:0] ram_q [USER_RAM_BYTES];
  logic boot_q;

  wire dbl = cfg_act_q[CFG_DBL_BIT];
  // the page register answers at 0xfc whatever the page holds
  wire in_page_sgl = !dbl && (acc_ptr[7:2] == PAGE_OFFSET_SGL[7:2]);
  wire [15:0] eff_addr = dbl ? acc_ptr :
    in_page_sgl ? {PAGE_HIGH_BYTE, acc_ptr[7:0]} : {page_q[15:8], acc_ptr[7:0]};
  wire user_half = eff_addr[15];
  wire is_page = eff_addr[15:2] == PAGE_OFFSET_DBL[15:2];
  wire is_base = eff_addr == BASE_ADDR_OFFSET;
  wire is_cfg = eff_addr == PORT_CFG_OFFSET;
  wire is_stat = eff_addr == PORT_STATUS_OFFSET;
  wire is_ram = eff_addr[15:4] == USER_RAM_BASE[15:4];
  wire [4:0] page_lsb = {eff_addr[1:0], 3'b000};
  wire [7:0] page_byte = page_q[page_lsb +: 8];
  wire [7:0] stat_byte = {5'h00, seq_done, cfg_act_q[CFG_SPI_BIT], dbl};
  wire [7:0] rd_mux = !user_half ? 8'h00 : is_page ? page_byte :
    is_base ? {1'b0, base_sh_q} : is_cfg ? {6'h00, cfg_sh_q} :
    is_stat ? stat_byte : is_ram ? ram_q[eff_addr[3:0]] : 8'h00;
  // writes below the user half are dropped
  wire do_wr = acc_stb && acc_wr && user_half;

  always_ff @(posedge clk)
  begin
    if (srst)
      page_q <= PAGE_RESET;
    else if (do_wr && is_page)
      page_q[page_lsb +: 8] <= acc_wdata;
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < USER_RAM_BYTES; i++)
      if (srst)
        ram_q[i] <= 8'h00;
      else if (do_wr && is_ram && eff_addr[3:0] == i[3:0])
        ram_q[i] <= acc_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_q <= 8'h00;
    else if (acc_stb && !acc_wr)
      rdata_q <= rd_mux;
  end

  // shadow copies take bus writes; the port sees bus writes only when the burst ends
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      base_sh_q <= DEV_ADDR_RESET;
      base_act_q <= DEV_ADDR_RESET;
      cfg_sh_q <= CFG_RESET;
      cfg_act_q <= CFG_RESET;
      boot_q <= 1'b1;
      cfg_upd_q <= 1'b0;
    end
    else
    begin
      boot_q <= 1'b0;
      cfg_upd_q <= boot_q || cfg_load_stb || commit;
      if (boot_q)
      begin
        // straps are caught on the first edge after release
        base_sh_q[ADDR_BIT_TWO] <= bit_two_strap_en ? bit_two_strap_s : DEV_ADDR_RESET[ADDR_BIT_TWO];
        base_act_q[ADDR_BIT_TWO] <= bit_two_strap_en ? bit_two_strap_s : DEV_ADDR_RESET[ADDR_BIT_TWO];
        cfg_sh_q[CFG_SPI_BIT] <= strap_spi_s;
        cfg_act_q[CFG_SPI_BIT] <= strap_spi_s;
      end
      if (cfg_load_stb)
      begin
        base_sh_q <= cfg_load_base;
        base_act_q <= cfg_load_base;
      end
      if (do_wr && is_base)
        base_sh_q <= acc_wdata[6:0];
      if (do_wr && is_cfg)
        cfg_sh_q <= acc_wdata[1:0];
      if (commit)
      begin
        base_act_q <= base_sh_q;
        cfg_act_q <= cfg_sh_q;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_lower_half_zero: assert property (acc_stb && !acc_wr && !user_half |=> rdata_q == 8'h00)
    else $error("read below user half returned nonzero");
  a_page_high_write: assert property (do_wr && eff_addr == 16'hfffd |=> page_q[15:8] == $past(acc_wdata))
    else $error("page high byte not written");
  a_cfg_held_mid_burst: assert property (!commit && !boot_q && !cfg_load_stb |=> cfg_act_q == $past(cfg_act_q))
    else $error("active config changed inside a burst");
  a_base_default: assert property (boot_q |-> base_act_q[6:3] == DEV_ADDR_RESET[6:3])
    else $error("base address not at default after reset");
  a_paged_read_map: assert property (acc_stb && !dbl && !in_page_sgl |-> eff_addr[15:8] == page_q[15:8])
    else $error("single byte offset not joined to page");
endmodule : spt_reg_store
`default_nettype wire

// [core/spt_target_port.sv]
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - target port answers register accesses once the reset sequence is done, protocol selectable.
// - port configuration written in one burst takes effect at the burst's end.
// - sixteen-bit offset spans 64KB; only the upper 32KB holds user registers.
// - offsets come whole per burst or combine with a per-port page register.
// - seven-bit base address resets to 1011000b or loads from stored configuration.
// - base address bits 0 and 1 follow the two strap pins in two-wire mode.
// - a strap level caught at reset may set base address bit 2.
// - only bus addresses equal to the formed base address get acknowledged.
// - every offset bit addresses registers since read/write rides with the address.
// - single-byte mode joins page bits 15:8 above the offset byte.
// - single-byte mode reaches the page register at 0xfc, written in one burst.
// - two-byte mode takes the full address; page set once at 0xfffc.
// - the pointer advances by one after every data byte written and every read byte the controller acknowledges.
// - the bus runs at 100kHz, 400kHz and 1MHz.
// - in four-wire mode the two-wire engine keeps off the bus; the strap pins are not used as select and data in.
module spt_target_port
  import spt_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link sampling clock
  input wire logic link_clk,
  // two-wire bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // shared strap pins
  input wire logic select_or_strap_low_pin,
  input wire logic serial_in_or_strap_high_pin,
  input wire logic addr_bit_two_default,
  input wire logic proto_strap_spi,
  // reset sequence and stored configuration
  input wire logic bit_two_strap_en,
  input wire logic reset_seq_done,
  input wire logic cfg_load_stb,
  input wire logic [6:0] cfg_load_base,
  // active mode
  output logic port_spi_mode,
  output logic port_dbl_mode
);
  // link side registers
  spt_state_t state_q, state_d;
  spt_role_t role_q, role_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] ptr_q, ptr_d;
  logic rd_q, rd_d;
  logic req_ev;
  logic stop_ev;
  logic req_tog_q, stop_tog_q, ack_seen_q, cfg_seen_q, addressed_q;
  logic scl_p_q, sda_p_q, sda_oe_q, scl_oe_q;
  logic [6:0] base_l_q;
  logic dbl_l_q, spi_l_q;
  logic [7:0] link_s;
  // core side registers
  logic [3:0] core_s;
  logic req_seen_q, stop_seen_q, ack_tog_q, cfg_tog_q;
  logic [7:0] rdata_q;
  logic [6:0] base_act;
  logic [1:0] cfg_act;
  logic cfg_upd;

  // bus pins, shared strap pins, srst, the core toggles and reset_seq_done pass two link flops first
  spt_sync #(.WIDTH(8)) u_link_sync (
    .clk(link_clk),
    .d({srst, scl_i, sda_i, select_or_strap_low_pin, serial_in_or_strap_high_pin,
        ack_tog_q, cfg_tog_q, reset_seq_done}),
    .q(link_s)
  );

  spt_sync #(.WIDTH(4)) u_core_sync (
    .clk(core_clk),
    .d({req_tog_q, stop_tog_q, addr_bit_two_default, proto_strap_spi}),
    .q(core_s)
  );

  wire lrst = link_s[7];
  wire scl_s = link_s[6];
  wire sda_s = link_s[5];
  wire strap_low_s = link_s[4];
  wire strap_high_s = link_s[3];
  wire ack_s = link_s[2];
  wire cfg_s = link_s[1];
  wire done_s = link_s[0];

  // core side: one access per request toggle, answered by the ack toggle
  wire acc_stb = core_s[3] != req_seen_q;
  wire commit = core_s[2] != stop_seen_q;

  spt_reg_store u_store (
    .clk(core_clk),
    .srst(srst),
    .acc_stb(acc_stb),
    .acc_wr(!rd_q),
    .acc_ptr(ptr_q),
    .acc_wdata(sh_q),
    .rdata_q(rdata_q),
    .commit(commit),
    .cfg_load_stb(cfg_load_stb),
    .cfg_load_base(cfg_load_base),
    .bit_two_strap_en(bit_two_strap_en),
    .bit_two_strap_s(core_s[1]),
    .strap_spi_s(core_s[0]),
    .seq_done(reset_seq_done),
    .base_act_q(base_act),
    .cfg_act_q(cfg_act),
    .cfg_upd_q(cfg_upd)
  );

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      req_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      ack_tog_q <= 1'b0;
      cfg_tog_q <= 1'b0;
      port_spi_mode <= 1'b0;
      port_dbl_mode <= 1'b0;
    end
    else
    begin
      req_seen_q <= core_s[3];
      stop_seen_q <= core_s[2];
      ack_tog_q <= ack_tog_q ^ acc_stb;
      cfg_tog_q <= cfg_tog_q ^ cfg_upd;
      port_spi_mode <= cfg_act[CFG_SPI_BIT];
      port_dbl_mode <= cfg_act[CFG_DBL_BIT];
    end
  end

  // link side: bus events from the sampled pins
  wire scl_rise = scl_s && !scl_p_q;
  wire scl_fall = !scl_s && scl_p_q;
  wire start = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire stop = scl_s && scl_p_q && !sda_p_q && sda_s;
  wire core_done = ack_s != ack_seen_q;
  wire byte_done = state_q == ST_RX && scl_fall && cnt_q == BITS_PER_BYTE && !start && !stop;
  // straps are read live; they are expected to stay put while the port is in use
  wire [6:0] match_addr = {base_l_q[6:2], strap_high_s, strap_low_s};
  // four-wire mode and the reset sequence keep this engine off the bus
  wire addr_hit = sh_q[7:1] == match_addr && !spi_l_q && done_s;
  // single-byte mode wraps in the page; the controller must not cross 0xff
  wire [15:0] ptr_inc = dbl_l_q ? ptr_q + 16'h0001 : {ptr_q[15:8], ptr_q[7:0] + 8'h01};

  always_comb
  begin
    state_d = state_q;
    role_d = role_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    req_ev = 1'b0;
    stop_ev = 1'b0;
    if (start)
    begin
      // pointer survives a repeated start so a read follows the offset
      state_d = ST_RX;
      role_d = ROLE_DEV;
      cnt_d = 4'h0;
    end
    else if (stop)
    begin
      state_d = ST_IDLE;
      stop_ev = addressed_q;
    end
    else
    begin
      case (state_q)
        ST_RX:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_d = 4'h0;
            state_d = ST_ACK;
            case (role_q)
              ROLE_DEV:
              begin
                rd_d = sh_q[0];
                role_d = dbl_l_q ? ROLE_OFF_HI : ROLE_OFF_LO;
                if (!addr_hit)
                  state_d = ST_IGNORE;
              end
              ROLE_OFF_HI:
              begin
                ptr_d[15:8] = sh_q;
                role_d = ROLE_OFF_LO;
              end
              ROLE_OFF_LO:
              begin
                ptr_d[7:0] = sh_q;
                role_d = ROLE_DATA;
              end
              default:
              begin
                // write lands first, acknowledge after the core confirms
                req_ev = 1'b1;
                state_d = ST_WAIT;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            state_d = rd_q ? ST_WAIT : ST_RX;
            req_ev = rd_q;
          end
        end
        ST_WAIT:
        begin
          if (core_done && rd_q)
          begin
            sh_d = rdata_q;
            cnt_d = 4'h0;
            state_d = ST_TX;
          end
          else if (core_done)
          begin
            ptr_d = ptr_inc;
            state_d = ST_ACK;
          end
        end
        ST_TX:
        begin
          if (scl_fall && cnt_q == LAST_TX_BIT)
            state_d = ST_TXACK;
          else if (scl_fall)
          begin
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end
        ST_TXACK:
        begin
          if (scl_rise && sda_s)
            state_d = ST_IGNORE;
          else if (scl_rise)
          begin
            ptr_d = ptr_inc;
            cnt_d = BITS_PER_BYTE;
          end
          else if (scl_fall && cnt_q == BITS_PER_BYTE)
          begin
            req_ev = 1'b1;
            state_d = ST_WAIT;
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      state_q <= ST_IDLE;
      role_q <= ROLE_DEV;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 16'h0000;
      rd_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      role_q <= role_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // crossings and pin drivers; scl is held low while the core works
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      req_tog_q <= 1'b0;
      stop_tog_q <= 1'b0;
      ack_seen_q <= 1'b0;
      cfg_seen_q <= 1'b0;
      addressed_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      base_l_q <= DEV_ADDR_RESET;
      dbl_l_q <= 1'b0;
      spi_l_q <= 1'b0;
    end
    else
    begin
      req_tog_q <= req_tog_q ^ req_ev;
      stop_tog_q <= stop_tog_q ^ stop_ev;
      ack_seen_q <= ack_s;
      cfg_seen_q <= cfg_s;
      addressed_q <= stop ? 1'b0 : (addressed_q || (byte_done && role_q == ROLE_DEV && addr_hit));
      sda_oe_q <= state_d == ST_ACK || (state_d == ST_TX && !sh_d[7]);
      scl_oe_q <= state_d == ST_WAIT;
      if (cfg_s != cfg_seen_q)
      begin
        // the bundle settled in the core before its toggle flipped
        base_l_q <= base_act;
        dbl_l_q <= cfg_act[CFG_DBL_BIT];
        spi_l_q <= cfg_act[CFG_SPI_BIT];
      end
    end
  end

  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign scl_oe = scl_oe_q;

  a_quiet_before_done: assert property (@(posedge link_clk) disable iff (lrst)
    !done_s && state_q != ST_WAIT |-> ##1 !sda_oe_q || state_q == ST_TX)
    else $error("port drove sda before reset sequence done");
  a_miss_ignored: assert property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_DEV && !addr_hit |=> state_q == ST_IGNORE && !sda_oe_q)
    else $error("unmatched address was acknowledged");
  a_hit_acked: assert property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_DEV && addr_hit |=> sda_oe_q && state_q == ST_ACK)
    else $error("matched address not acknowledged");
  a_spi_silent: assert property (@(posedge link_clk) disable iff (lrst)
    spi_l_q && state_q != ST_WAIT && state_q != ST_TX |=> !sda_oe_q || state_q == ST_TX)
    else $error("two-wire engine active in four-wire mode");
  a_offset_high: assert property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_OFF_HI |=> ptr_q[15:8] == $past(sh_q) && role_q == ROLE_OFF_LO)
    else $error("high offset byte not captured");
  a_offset_low: assert property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_OFF_LO |=> ptr_q[7:0] == $past(sh_q) && role_q == ROLE_DATA)
    else $error("low offset byte not captured");
  a_ptr_step_write: assert property (@(posedge link_clk) disable iff (lrst)
    state_q == ST_WAIT && core_done && !rd_q && !start && !stop
    |=> ptr_q[7:0] == $past(ptr_q[7:0]) + 8'h01)
    else $error("pointer did not advance after write");
  a_write_waits_core: assert property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_DATA |=> scl_oe_q && !sda_oe_q)
    else $error("data byte acknowledged before store");
  a_page_wrap_sgl: assert property (@(posedge link_clk) disable iff (lrst)
    state_q == ST_TXACK && scl_rise && !sda_s && !dbl_l_q && !start && !stop
    |=> ptr_q[15:8] == $past(ptr_q[15:8]))
    else $error("single byte pointer left its page");

  c_write_data: cover property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_DATA);
  c_read_acked: cover property (@(posedge link_clk) disable iff (lrst)
    state_q == ST_TXACK && scl_rise && !sda_s);
  c_two_byte_offset: cover property (@(posedge link_clk) disable iff (lrst)
    byte_done && role_q == ROLE_OFF_HI);
endmodule : spt_target_port
`default_nettype wire

// [verif/spt_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module spt_ctrl_model (
  // link clock and resolved bus lines
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  // open-drain pulls, high = pull low
  output logic scl_oe,
  output logic sda_oe,
  // a stretch that never ended
  output logic stuck
);
  // 60 link cycles a bit; a little above the top rate keeps the run short
  localparam int HALF = 30;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stuck = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask : tick
  // the target may stretch, so wait for the line, not a fixed time
  task automatic scl_up();
    int i;
    scl_oe <= 1'b0;
    for (i = 0; i < 4000 && scl_i !== 1'b1; i++) @(posedge link_clk);
    if (scl_i !== 1'b1) stuck <= 1'b1;
  endtask : scl_up
  task automatic xfer_bit(input logic b, output logic s);
    tick(4);
    sda_oe <= ~b;
    tick(HALF - 4);
    scl_up();
    tick(HALF / 2);
    s = sda_i;
    tick(HALF / 2);
    scl_oe <= 1'b1;
  endtask : xfer_bit
  // also serves as repeated start, from scl low
  task automatic start();
    tick(4);
    sda_oe <= 1'b0;
    tick(HALF);
    scl_up();
    tick(HALF);
    sda_oe <= 1'b1;
    tick(HALF);
    scl_oe <= 1'b1;
  endtask : start
  task automatic stop();
    tick(4);
    sda_oe <= 1'b1;
    tick(HALF);
    scl_up();
    tick(HALF);
    sda_oe <= 1'b0;
    tick(HALF);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer_bit(b[i], s);
    xfer_bit(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // whole registers go in one burst, never past the page end
  task automatic write_burst(input logic [6:0] dev, input logic [7:0] b[$], output logic acked);
    logic a;
    start();
    wbyte({dev, 1'b0}, acked);
    foreach (b[i]) wbyte(b[i], a);
    stop();
  endtask : write_burst
  task automatic read_burst(input logic [6:0] dev, input logic [7:0] off[$], input int n,
                            output logic [7:0] d[$], output logic acked);
    logic a;
    logic [7:0] v;
    d = {};
    start();
    wbyte({dev, 1'b0}, acked);
    foreach (off[i]) wbyte(off[i], a);
    start();
    wbyte({dev, 1'b1}, a);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--) xfer_bit(1'b1, v[i]);
      xfer_bit(k == n - 1, a);
      d.push_back(v);
    end
    stop();
  endtask : read_burst
endmodule : spt_ctrl_model
`default_nettype wire

// [verif/paged_i2c_target_register_port_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module paged_i2c_target_register_port_tb;
  import spt_pkg::*;
  logic core_clk, link_clk, srst, seq_done, strap_lo, strap_hi, cfg_stb;
  logic [6:0] cfg_base;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, stuck, spi_mode, dbl_mode;
  wire scl_line;
  wire sda_line;
  int num_errors = 0;
  int samples_checked = 0;
  // pull-ups: a line is low whenever anyone pulls it
  assign scl_line = ~(scl_oe | m_scl_oe);
  assign sda_line = ~(sda_oe | m_sda_oe);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #6 link_clk = ~link_clk;
  end
  spt_target_port u_dut (
    .core_clk(core_clk), .srst(srst), .link_clk(link_clk),
    .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe),
    .select_or_strap_low_pin(strap_lo), .serial_in_or_strap_high_pin(strap_hi),
    .addr_bit_two_default(1'b0), .proto_strap_spi(1'b0), .bit_two_strap_en(1'b0),
    .reset_seq_done(seq_done), .cfg_load_stb(cfg_stb), .cfg_load_base(cfg_base),
    .port_spi_mode(spi_mode), .port_dbl_mode(dbl_mode)
  );
  spt_ctrl_model u_ctrl (
    .link_clk(link_clk), .scl_i(scl_line), .sda_i(sda_line),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .stuck(stuck)
  );
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic hang_check();
    if (stuck === 1'b1)
    begin
      num_errors++;
      results();
    end
  endtask : hang_check
  task automatic wr(input logic [6:0] dev, input logic [7:0] b[$], input logic exp_ack);
    logic a;
    u_ctrl.write_burst(dev, b, a);
    hang_check();
    check("address ack", {7'h0, a}, {7'h0, exp_ack});
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] off[$], input logic [7:0] exp[$]);
    logic [7:0] got[$];
    logic a;
    u_ctrl.read_burst(dev, off, exp.size(), got, a);
    hang_check();
    check("read ack", {7'h0, a}, 8'h01);
    foreach (exp[i]) check("read data", got[i], exp[i]);
  endtask : rd
  // a hung bus or engine still ends in the report
  initial
  begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    results();
  end
  initial
  begin
    srst = 1'b1;
    seq_done = 1'b0;
    strap_lo = 1'b0;
    strap_hi = 1'b0;
    cfg_stb = 1'b0;
    cfg_base = 7'h0;
    // longer than three cycles: the link side needs two of its own edges
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    repeat (40) @(posedge core_clk);
    check("mode after reset", {6'h0, spi_mode, dbl_mode}, 8'h00);
    wr(DEV_ADDR_RESET, '{8'h03}, 1'b0);
    @(posedge core_clk);
    seq_done <= 1'b1;
    wr(DEV_ADDR_RESET, '{PAGE_OFFSET_SGL, 8'h00, 8'h80, 8'h00, 8'h00}, 1'b1);
    rd(DEV_ADDR_RESET, '{PAGE_OFFSET_SGL}, '{8'h00, 8'h80, 8'h00, 8'h00});
    wr(DEV_ADDR_RESET, '{8'h03, 8'h50, 8'h51}, 1'b1);
    rd(DEV_ADDR_RESET, '{8'h03}, '{8'h50, 8'h51});
    $display("test paged access done");
    @(posedge core_clk);
    strap_lo <= 1'b1;
    strap_hi <= 1'b1;
    wr(DEV_ADDR_RESET | 7'h3, '{8'h04, 8'h60}, 1'b1);
    wr(DEV_ADDR_RESET | 7'h1, '{8'h04, 8'h61}, 1'b0);
    rd(DEV_ADDR_RESET | 7'h3, '{8'h04}, '{8'h60});
    @(posedge core_clk);
    strap_lo <= 1'b0;
    strap_hi <= 1'b0;
    cfg_base <= 7'h24;
    cfg_stb <= 1'b1;
    @(posedge core_clk);
    cfg_stb <= 1'b0;
    wr(7'h24, '{8'h05, 8'h77}, 1'b1);
    wr(DEV_ADDR_RESET, '{8'h05, 8'h00}, 1'b0);
    rd(7'h24, '{8'h05}, '{8'h77});
    @(posedge core_clk);
    cfg_base <= DEV_ADDR_RESET;
    cfg_stb <= 1'b1;
    @(posedge core_clk);
    cfg_stb <= 1'b0;
    $display("test address match done");
    wr(DEV_ADDR_RESET, '{PAGE_OFFSET_SGL, 8'h00, PAGE_HIGH_BYTE, 8'h00, 8'h00}, 1'b1);
    wr(DEV_ADDR_RESET, '{8'hf1, 8'h01}, 1'b1);
    repeat (20) @(posedge core_clk);
    check("two-byte mode", {7'h0, dbl_mode}, 8'h01);
    rd(DEV_ADDR_RESET, '{8'hff, 8'hf1}, '{8'h01});
    wr(DEV_ADDR_RESET, '{8'h80, 8'h0e, 8'ha5, 8'h5a}, 1'b1);
    rd(DEV_ADDR_RESET, '{8'h80, 8'h0e}, '{8'ha5, 8'h5a});
    wr(DEV_ADDR_RESET, '{8'h10, 8'h00, 8'h33}, 1'b1);
    rd(DEV_ADDR_RESET, '{8'h10, 8'h00}, '{8'h00});
    rd(DEV_ADDR_RESET, '{8'hff, 8'hfc}, '{8'h00, 8'hff, 8'h00, 8'h00});
    $display("test two-byte offsets done");
    wr(DEV_ADDR_RESET, '{8'hff, 8'hf1, 8'h03}, 1'b1);
    repeat (20) @(posedge core_clk);
    check("four-wire mode", {7'h0, spi_mode}, 8'h01);
    wr(DEV_ADDR_RESET, '{8'h00}, 1'b0);
    $display("test protocol switch done");
    results();
  end
endmodule : paged_i2c_target_register_port_tb
`default_nettype wire
